// file: logic/pcam_core.sv
// Alarm handling and setpoint arbitration of the control function
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps

// Summary of operation
// - Three alarms: closed loop, transfer active, control limit active.
// - Each alarm disabled by its register bit or by an external input.
// - Detection flag is high while the alarm condition is present.
// - Signalling output asserts on alarm; held when latching configured.
// - Latching chosen per alarm independently.
// - Valid acknowledge clears the alarm's signalling output.
// - Acknowledge bits self-clear; writing them is a one-cycle pulse.
// - Acknowledge ignored while detection is still active.
// - Per-alarm acknowledged / unacknowledged status is reported.
// - Main target is nominal value times ramped demand (setpoint capped at 100) divided by 100.
// - Enabled transfer or limit overrides the main setpoint target.
// - Three limit loops, each with own input and setpoint.
// - Limit control acts only when limit enable is set.
// - Transfer input and span take effect only with transfer enabled.
// - Separate integral times for main and limit loops.
// - Limiting: phase mode reduces angle; burst mode fires reduced bursts.
// - Modulation target keeps following the main setpoint while limiting.
// - Standby demands zero; leaving standby ramps back up.
module pcam_core
  import pcam_pkg::*;
#(
  parameter int W = 16
)
(
  input  wire logic           mclk_i,                 // 250 MHz clock
  input  wire logic           rst_i,                  // Async reset
  input  wire logic [AW-1:0]  addr_i,                 // Register address
  input  wire logic [31:0]    wdata_i,                // Write data
  input  wire logic           wr_i,                   // Write strobe
  input  wire logic           rd_i,                   // Read strobe
  output logic      [31:0]    rdata_o,                // Read data
  input  wire logic [W-1:0]   process_value_i,        // Main measurement
  input  wire logic [W-1:0]   transfer_measurement_i, // Transfer input
  input  wire logic [3*W-1:0] limit_inputs_i,         // Limit loop inputs
  input  wire logic           loop_break_i,           // Closed loop fault
  input  wire logic [2:0]     alm_dis_ext_i,          // Wired disables
  output logic      [W-1:0]   target_o,               // Regulation target
  output logic      [W-1:0]   mod_target_o,           // Modulation target
  output logic      [7:0]     demand_o,               // Ramped demand pct
  output logic                angle_reduce_o,         // Phase angle cut
  output logic                burst_reduce_o,         // Reduced bursts
  output logic      [W-1:0]   ti_main_o,              // Main integral time
  output logic      [W-1:0]   ti_limit_o,             // Limit integral time
  output logic      [2:0]     alm_det_o,              // Alarm detection
  output logic      [2:0]     alm_sig_o,              // Alarm signalling
  output logic      [2:0]     alm_unack_o,            // Unacknowledged
  output logic                irq_o                   // Interrupt level
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0]          ctrl;
    logic [7:0]          main_sp;
    logic [W-1:0]        nominal;
    logic [W-1:0]        span;
    logic [W-1:0]        ti_main;
    logic [W-1:0]        ti_limit;
    logic [2:0][W-1:0]   lim_sp;
    logic [2:0]          dis;
    logic [2:0]          latch;
    logic [2:0]          det;
    logic [2:0]          sig;
    logic [2:0]          unack;
    logic [2:0]          int_stat;
    logic [2:0]          int_mask;
    logic                irq;
    pcam_mode_t          mode;
    logic [7:0]          demand;
    logic [RCW-1:0]      ramp_cnt;
    logic [W-1:0]        target;
    logic [W-1:0]        mod_target;
    logic                angle_red;
    logic                burst_red;
    logic [31:0]         rdata;
  } pcam_state_t;

  pcam_state_t st_r;
  pcam_state_t st_nxt;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic at_or_over(input logic [W-1:0] meas,
                                      input logic [W-1:0] thr);
    return meas >= thr;
  endfunction

  function automatic logic [W-1:0] pct_of(input logic [W-1:0] nom,
                                          input logic [7:0]   pct);
    logic [W+7:0] prod;
    prod = nom * pct;
    return W'(prod / (W+8)'(PCT_FULL));
  endfunction

  function automatic logic ack_ok(input logic ack_bit,
                                  input logic det_now);
    // Refused while the alarm is still detected
    return ack_bit & ~det_now;
  endfunction

  // ---------------------------------------------------------------
  // Combinational part
  // ---------------------------------------------------------------
  logic [2:0]   cond;
  logic [2:0]   eff_dis;
  logic [2:0]   ack;
  logic [2:0]   ack_vld;
  logic [2:0]   lim_hit;
  logic         lim_act;
  logic         trans_act;
  logic         ramp_tick;
  logic [W-1:0] main_t;
  logic [W-1:0] lim_t;
  logic [7:0]   sp_clip;

  always_comb
  begin
    st_nxt  = st_r;
    lim_t   = '0;
    lim_hit = '0;
    ack     = '0;
    ack_vld = '0;

    // -------------------------------------------------------------
    // Register writes
    // -------------------------------------------------------------
    if (wr_i)
    begin
      case (addr_i)
        OFF_CTRL:      st_nxt.ctrl     = wdata_i[3:0];
        OFF_MAIN_SP:   st_nxt.main_sp  = wdata_i[7:0];
        OFF_NOMINAL:   st_nxt.nominal  = wdata_i[W-1:0];
        OFF_SPAN:      st_nxt.span     = wdata_i[W-1:0];
        OFF_TI_MAIN:   st_nxt.ti_main  = wdata_i[W-1:0];
        OFF_TI_LIMIT:  st_nxt.ti_limit = wdata_i[W-1:0];
        OFF_LIM_SP0:   st_nxt.lim_sp[0] = wdata_i[W-1:0];
        OFF_LIM_SP1:   st_nxt.lim_sp[1] = wdata_i[W-1:0];
        OFF_LIM_SP2:   st_nxt.lim_sp[2] = wdata_i[W-1:0];
        OFF_ALM_DIS:   st_nxt.dis      = wdata_i[2:0];
        OFF_ALM_LATCH: st_nxt.latch    = wdata_i[2:0];
        OFF_ALM_ACK:   ack             = wdata_i[2:0];
        OFF_INT_MASK:  st_nxt.int_mask = wdata_i[2:0];
        // Read-only offsets fall here and are ignored
        default:       ;
      endcase
    end

    // -------------------------------------------------------------
    // Limit loops, only with limit enabled
    // -------------------------------------------------------------
    // A zero setpoint counts as always exceeded
    for (int i = 0; i < 3; i++)
    begin
      lim_hit[i] = at_or_over(limit_inputs_i[i*W +: W], st_r.lim_sp[i]);
    end
    lim_act = st_r.ctrl[CTRL_LIM_EN] & (|lim_hit);
    // Lowest-numbered loop over its setpoint wins
    for (int i = 2; i >= 0; i--)
    begin
      if (lim_hit[i])
      begin
        lim_t = st_r.lim_sp[i];
      end
    end

    // -------------------------------------------------------------
    // Transfer only with transfer enabled
    // -------------------------------------------------------------
    trans_act = st_r.ctrl[CTRL_TRANS_EN]
              & at_or_over(transfer_measurement_i, st_r.span);

    // -------------------------------------------------------------
    // Alarm conditions
    // -------------------------------------------------------------
    cond[ALM_CLOSED] = loop_break_i;
    cond[ALM_TRANS]  = trans_act;
    cond[ALM_LIMIT]  = lim_act;
    eff_dis          = st_r.dis | alm_dis_ext_i;

    for (int i = 0; i < NALM; i++)
    begin
      ack_vld[i] = ack_ok(ack[i], st_r.det[i]);
    end

    for (int i = 0; i < NALM; i++)
    begin
      st_nxt.det[i] = cond[i] & ~eff_dis[i];
      if (!st_r.latch[i])
      begin
        st_nxt.sig[i] = st_nxt.det[i];
      end
      else if (st_nxt.det[i])
      begin
        st_nxt.sig[i] = 1'b1;
      end
      else if (ack_vld[i])
      begin
        st_nxt.sig[i] = 1'b0;
      end
      if (st_nxt.det[i] && !st_r.det[i])
      begin
        st_nxt.unack[i] = 1'b1;
      end
      else if (ack_vld[i])
      begin
        st_nxt.unack[i] = 1'b0;
      end
    end

    // -------------------------------------------------------------
    // Sticky interrupt status, set beats write-one clear
    // -------------------------------------------------------------
    if (wr_i && addr_i == OFF_INT_STAT)
    begin
      st_nxt.int_stat = st_r.int_stat & ~wdata_i[2:0];
    end
    st_nxt.int_stat = st_nxt.int_stat | (st_nxt.sig & ~st_r.sig);
    st_nxt.irq      = |(st_nxt.int_stat & st_nxt.int_mask);

    // -------------------------------------------------------------
    // Standby and ramped return
    // -------------------------------------------------------------
    sp_clip   = (st_r.main_sp > PCT_FULL) ? PCT_FULL : st_r.main_sp;
    // Free-running divider, first step 1 to RAMP_CYC cycles late
    ramp_tick = (st_r.ramp_cnt == RCW'(RAMP_CYC - 1));
    st_nxt.ramp_cnt = ramp_tick ? '0 : st_r.ramp_cnt + 1'b1;
    case (st_r.mode)
      PCAM_ST_STANDBY:
      begin
        st_nxt.demand = '0;
        if (!st_r.ctrl[CTRL_STANDBY])
        begin
          st_nxt.mode = PCAM_ST_RAMP;
        end
      end
      PCAM_ST_RAMP:
      begin
        if (st_r.ctrl[CTRL_STANDBY])
        begin
          st_nxt.mode = PCAM_ST_STANDBY;
        end
        else if (st_r.demand >= sp_clip)
        begin
          st_nxt.demand = sp_clip;
          st_nxt.mode   = PCAM_ST_RUN;
        end
        else if (ramp_tick)
        begin
          st_nxt.demand = st_r.demand + 8'h01;
        end
      end
      PCAM_ST_RUN:
      begin
        if (st_r.ctrl[CTRL_STANDBY])
        begin
          st_nxt.mode = PCAM_ST_STANDBY;
        end
        else if (st_r.demand < sp_clip)
        begin
          st_nxt.mode = PCAM_ST_RAMP;
        end
        else
        begin
          st_nxt.demand = sp_clip;
        end
      end
      default:
      begin
        st_nxt.mode   = PCAM_ST_STANDBY;
        st_nxt.demand = '0;
      end
    endcase

    // -------------------------------------------------------------
    // Target arbitration
    // -------------------------------------------------------------
    main_t = pct_of(st_r.nominal, st_r.demand);
    st_nxt.mod_target = main_t;
    if (st_r.mode == PCAM_ST_STANDBY)
    begin
      st_nxt.target = '0;
    end
    else if (lim_act)
    begin
      st_nxt.target = lim_t;
    end
    else if (trans_act)
    begin
      st_nxt.target = st_r.span;
    end
    else
    begin
      st_nxt.target = main_t;
    end
    st_nxt.angle_red = lim_act & ~st_r.ctrl[CTRL_BURST];
    st_nxt.burst_red = lim_act &  st_r.ctrl[CTRL_BURST];

    // -------------------------------------------------------------
    // Read data, valid the cycle after the strobe
    // -------------------------------------------------------------
    st_nxt.rdata = '0;
    if (rd_i)
    begin
      case (addr_i)
        OFF_CTRL:      st_nxt.rdata[3:0]   = st_r.ctrl;
        OFF_MAIN_SP:   st_nxt.rdata[7:0]   = st_r.main_sp;
        OFF_NOMINAL:   st_nxt.rdata[W-1:0] = st_r.nominal;
        OFF_SPAN:      st_nxt.rdata[W-1:0] = st_r.span;
        OFF_TI_MAIN:   st_nxt.rdata[W-1:0] = st_r.ti_main;
        OFF_TI_LIMIT:  st_nxt.rdata[W-1:0] = st_r.ti_limit;
        OFF_LIM_SP0:   st_nxt.rdata[W-1:0] = st_r.lim_sp[0];
        OFF_LIM_SP1:   st_nxt.rdata[W-1:0] = st_r.lim_sp[1];
        OFF_LIM_SP2:   st_nxt.rdata[W-1:0] = st_r.lim_sp[2];
        OFF_ALM_DIS:   st_nxt.rdata[2:0]   = st_r.dis;
        OFF_ALM_LATCH: st_nxt.rdata[2:0]   = st_r.latch;
        OFF_ALM_ACK:   st_nxt.rdata        = '0;
        OFF_ALM_STAT:
        begin
          st_nxt.rdata[STAT_DET_LSB +: 3]  = st_r.det;
          st_nxt.rdata[STAT_SIG_LSB +: 3]  = st_r.sig;
          st_nxt.rdata[STAT_UACK_LSB +: 3] = st_r.unack;
        end
        OFF_INT_STAT:  st_nxt.rdata[2:0]   = st_r.int_stat;
        OFF_INT_MASK:  st_nxt.rdata[2:0]   = st_r.int_mask;
        OFF_DEMAND:    st_nxt.rdata[7:0]   = st_r.demand;
        OFF_TARGET:    st_nxt.rdata[W-1:0] = st_r.target;
        OFF_PV:        st_nxt.rdata[W-1:0] = process_value_i;
        default:       st_nxt.rdata        = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_r      <= '0;
      // Control word comes up in standby
      st_r.ctrl <= CTRL_RST;
      st_r.mode <= PCAM_ST_STANDBY;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rdata_o        = st_r.rdata;
  assign target_o       = st_r.target;
  assign mod_target_o   = st_r.mod_target;
  assign demand_o       = st_r.demand;
  assign angle_reduce_o = st_r.angle_red;
  assign burst_reduce_o = st_r.burst_red;
  assign ti_main_o      = st_r.ti_main;
  assign ti_limit_o     = st_r.ti_limit;
  assign alm_det_o      = st_r.det;
  assign alm_sig_o      = st_r.sig;
  assign alm_unack_o    = st_r.unack;
  assign irq_o          = st_r.irq;

endmodule

// file: logic/pcam_pkg.sv
// Constants for the power control alarm manager
package pcam_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam int          AW            = 8;
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_MAIN_SP   = 8'h04;
  localparam logic [7:0]  OFF_NOMINAL   = 8'h08;
  localparam logic [7:0]  OFF_SPAN      = 8'h0c;
  localparam logic [7:0]  OFF_TI_MAIN   = 8'h10;
  localparam logic [7:0]  OFF_TI_LIMIT  = 8'h14;
  localparam logic [7:0]  OFF_LIM_SP0   = 8'h18;
  localparam logic [7:0]  OFF_LIM_SP1   = 8'h1c;
  localparam logic [7:0]  OFF_LIM_SP2   = 8'h20;
  localparam logic [7:0]  OFF_ALM_DIS   = 8'h24;
  localparam logic [7:0]  OFF_ALM_LATCH = 8'h28;
  localparam logic [7:0]  OFF_ALM_ACK   = 8'h2c;
  localparam logic [7:0]  OFF_ALM_STAT  = 8'h30;
  localparam logic [7:0]  OFF_INT_STAT  = 8'h34;
  localparam logic [7:0]  OFF_INT_MASK  = 8'h38;
  localparam logic [7:0]  OFF_DEMAND    = 8'h3c;
  localparam logic [7:0]  OFF_TARGET    = 8'h40;
  localparam logic [7:0]  OFF_PV        = 8'h44;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int          CTRL_STANDBY  = 0;
  localparam int          CTRL_LIM_EN   = 1;
  localparam int          CTRL_TRANS_EN = 2;
  localparam int          CTRL_BURST    = 3;
  localparam logic [3:0]  CTRL_RST      = 4'h1;
  localparam int          NALM          = 3;
  localparam int          ALM_CLOSED    = 0;
  localparam int          ALM_TRANS     = 1;
  localparam int          ALM_LIMIT     = 2;
  localparam int          STAT_DET_LSB  = 0;
  localparam int          STAT_SIG_LSB  = 4;
  localparam int          STAT_UACK_LSB = 8;
  localparam logic [7:0]  PCT_FULL      = 8'h64;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          RAMP_STEP_NS  = 1000;
  localparam int          RAMP_CYC      = (RAMP_STEP_NS + CLK_PERIOD_NS - 1)
                                          / CLK_PERIOD_NS;
  localparam int          RCW           = 9;

  typedef enum logic [1:0] {
    PCAM_ST_STANDBY,
    PCAM_ST_RAMP,
    PCAM_ST_RUN
  } pcam_mode_t;

endpackage

// file: verif/pcam_core_assertions.sv
// Port-level checks for the alarm manager
`timescale 1ns/1ps
module pcam_core_assertions
  import pcam_pkg::*;
(
  input wire logic          mclk_i,        // Clock
  input wire logic          rst_i,         // Async reset
  input wire logic [AW-1:0] addr_i,        // Address
  input wire logic [31:0]   wdata_i,       // Write data
  input wire logic          wr_i,          // Write strobe
  input wire logic          loop_break_i,  // Closed loop fault
  input wire logic [2:0]    alm_dis_ext_i, // Wired disables
  input wire logic [7:0]    demand_o,      // Demand
  input wire logic [2:0]    alm_det_o,     // Detection
  input wire logic [2:0]    alm_sig_o,     // Signalling
  input wire logic [2:0]    alm_unack_o    // Unacknowledged
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // ---------------------------------------------------------------
  // Alarm properties
  // ---------------------------------------------------------------
  property p_ext_dis;
    (alm_det_o & $past(alm_dis_ext_i)) == 3'h0;
  endproperty
  a_ext_dis: assert property (p_ext_dis)
    else $error("detection despite wired disable");
  property p_det_cause;
    $rose(alm_det_o[0]) |-> $past(loop_break_i);
  endproperty
  a_det_cause: assert property (p_det_cause)
    else $error("detection without condition");
  property p_det_sig;
    (alm_det_o & ~alm_sig_o) == 3'h0;
  endproperty
  a_det_sig: assert property (p_det_sig)
    else $error("detection without signalling");
  property p_unack_rise;
    $rose(alm_det_o[0]) |-> alm_unack_o[0] && alm_sig_o[0];
  endproperty
  a_unack_rise: assert property (p_unack_rise)
    else $error("new alarm not unacknowledged");
  property p_ack_refused;
    wr_i && addr_i == OFF_ALM_ACK && wdata_i[0] && alm_det_o[0]
      && loop_break_i |=> alm_sig_o[0];
  endproperty
  a_ack_refused: assert property (p_ack_refused)
    else $error("active alarm acknowledged");
  property p_ack_clears;
    wr_i && addr_i == OFF_ALM_ACK && wdata_i[0] && !alm_det_o[0]
      && !loop_break_i |=> !alm_sig_o[0] && !alm_unack_o[0];
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("acknowledge did not clear alarm");

  // ---------------------------------------------------------------
  // Demand properties
  // ---------------------------------------------------------------
  property p_standby;
    wr_i && addr_i == OFF_CTRL && wdata_i[CTRL_STANDBY]
      |-> ##[1:3] demand_o == 8'h00;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby demand not zero");
  property p_ramp_step;
    demand_o > $past(demand_o) |-> demand_o == $past(demand_o) + 8'h01;
  endproperty
  a_ramp_step: assert property (p_ramp_step)
    else $error("demand rose by more than one");
endmodule

bind pcam_core pcam_core_assertions i_pcam_core_assertions (
  .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .loop_break_i(loop_break_i), .alm_dis_ext_i(alm_dis_ext_i),
  .demand_o(demand_o), .alm_det_o(alm_det_o), .alm_sig_o(alm_sig_o),
  .alm_unack_o(alm_unack_o)
);

// file: verif/tb_pcam_core.sv
// Self-checking bench for the alarm manager
`timescale 1ns/1ps
module tb_pcam_core
  import pcam_pkg::*;
;
  localparam int NOM = 500;
  localparam int SP  = 20;
  localparam int EXP = NOM * SP / 100;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [15:0] pv_i = 16'h1234;
  logic [15:0] meas_i = 16'h0;
  logic [47:0] lim_i = 48'h0;
  logic        loop_break_i = 1'b0;
  logic [2:0]  alm_dis_ext_i = 3'h0;
  logic [31:0] rdata_o;
  logic [15:0] target_o, mod_target_o, ti_main_o, ti_limit_o;
  logic [7:0]  demand_o;
  logic        angle_reduce_o, burst_reduce_o, irq_o;
  logic [2:0]  alm_det_o, alm_sig_o, alm_unack_o;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cyc = 0;

  always #2 mclk_i = ~mclk_i;

  pcam_core i_pcam_core (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .process_value_i(pv_i),
    .transfer_measurement_i(meas_i), .limit_inputs_i(lim_i),
    .loop_break_i(loop_break_i), .alm_dis_ext_i(alm_dis_ext_i),
    .target_o(target_o), .mod_target_o(mod_target_o),
    .demand_o(demand_o), .angle_reduce_o(angle_reduce_o),
    .burst_reduce_o(burst_reduce_o), .ti_main_o(ti_main_o),
    .ti_limit_o(ti_limit_o), .alm_det_o(alm_det_o), .alm_sig_o(alm_sig_o),
    .alm_unack_o(alm_unack_o), .irq_o(irq_o)
  );

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("Compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, e,
                    input string nm);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1;
    check(nm, rdata_o & m, e);
  endtask

  task automatic wait_dem(input logic [7:0] v);
    int k;
    k = 0;
    while (demand_o !== v && k < 6000)
    begin
      tick(1);
      k++;
    end
    #1;
    check("demand", 32'(demand_o), 32'(v));
  endtask

  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    rc(OFF_CTRL, 32'hffffffff, 32'(CTRL_RST), "ctrl");
    rc(8'h48, 32'hffffffff, 32'h0, "unmapped");
    rc(OFF_PV, 32'hffffffff, 32'h1234, "pv");
    wr(OFF_TI_MAIN, 32'h11);
    wr(OFF_TI_LIMIT, 32'h22);
    tick(2);
    check("ti_main", 32'(ti_main_o), 32'h11);
    check("ti_limit", 32'(ti_limit_o), 32'h22);
    wr(OFF_NOMINAL, 32'(NOM));
    wr(OFF_MAIN_SP, 32'(SP));
    wr(OFF_CTRL, 32'h0);
    wait_dem(8'(SP));
    tick(3);
    check("mod_target", 32'(mod_target_o), 32'(EXP));
    check("target", 32'(target_o), 32'(EXP));
    wr(OFF_LIM_SP0, 32'h32);
    wr(OFF_LIM_SP1, 32'h5);
    lim_i <= {16'h0, 16'h10, 16'h3c};
    tick(3);
    check("target_noen", 32'(target_o), 32'(EXP));
    wr(OFF_CTRL, 32'h2);
    tick(3);
    check("target_lim", 32'(target_o), 32'h32);
    check("angle", 32'({angle_reduce_o, burst_reduce_o}), 32'h2);
    check("mod_lim", 32'(mod_target_o), 32'(EXP));
    check("alm_lim", 32'({alm_sig_o, alm_det_o}), 32'h24);
    wr(OFF_CTRL, 32'ha);
    tick(3);
    check("burst", 32'({angle_reduce_o, burst_reduce_o}), 32'h1);
    wr(OFF_SPAN, 32'h28);
    meas_i <= 16'h2d;
    wr(OFF_CTRL, 32'h4);
    tick(3);
    check("target_tr", 32'(target_o), 32'h28);
    check("alm_tr", 32'({alm_sig_o, alm_det_o}), 32'h12);
    wr(OFF_CTRL, 32'h0);
    meas_i <= 16'h0;
    lim_i  <= 48'h0;
    tick(3);
    check("target_main", 32'(target_o), 32'(EXP));
    wr(OFF_INT_STAT, 32'h7);
    wr(OFF_INT_MASK, 32'h1);
    wr(OFF_ALM_LATCH, 32'h1);
    loop_break_i <= 1'b1;
    tick(3);
    check("alm_on", 32'({alm_unack_o[0], alm_sig_o[0], alm_det_o[0], irq_o}),
          32'hf);
    wr(OFF_ALM_ACK, 32'h1);
    tick(1);
    check("ack_active", 32'({alm_unack_o[0], alm_sig_o[0]}), 32'h3);
    loop_break_i <= 1'b0;
    tick(3);
    check("latched", 32'({alm_unack_o[0], alm_sig_o[0], alm_det_o[0]}),
          32'h6);
    rc(OFF_ALM_STAT, 32'h111, 32'h110, "stat");
    wr(OFF_ALM_ACK, 32'h1);
    tick(1);
    check("acked", 32'({alm_unack_o[0], alm_sig_o[0]}), 32'h0);
    rc(OFF_ALM_ACK, 32'hffffffff, 32'h0, "ack_rd");
    check("irq_held", 32'(irq_o), 32'h1);
    wr(OFF_INT_STAT, 32'h1);
    tick(2);
    check("irq_clr", 32'(irq_o), 32'h0);
    wr(OFF_ALM_LATCH, 32'h0);
    wr(OFF_INT_MASK, 32'h0);
    loop_break_i <= 1'b1;
    tick(3);
    check("nl_on", 32'({irq_o, alm_sig_o[0], alm_det_o[0]}), 32'h3);
    loop_break_i <= 1'b0;
    tick(3);
    check("nl_off", 32'({alm_unack_o[0], alm_sig_o[0], alm_det_o[0]}),
          32'h4);
    wr(OFF_INT_MASK, 32'h1);
    tick(2);
    check("irq_unmask", 32'(irq_o), 32'h1);
    wr(OFF_ALM_DIS, 32'h1);
    loop_break_i <= 1'b1;
    tick(3);
    check("dis_reg", 32'({alm_sig_o[0], alm_det_o[0]}), 32'h0);
    alm_dis_ext_i <= 3'h1;
    wr(OFF_ALM_DIS, 32'h0);
    tick(3);
    check("dis_ext", 32'({alm_sig_o[0], alm_det_o[0]}), 32'h0);
    loop_break_i  <= 1'b0;
    alm_dis_ext_i <= 3'h0;
    wr(OFF_CTRL, 32'h1);
    tick(3);
    check("standby", 32'({target_o, demand_o}), 32'h0);
    final_report();
  end
endmodule
